// ---- rtl/pin_pkg.sv ----
// constants for the pin, memory bus and serial logic
package pin_pkg;
  // register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_P0CFG = 8'h04;
  localparam logic [7:0] A_P0DATA = 8'h08;
  localparam logic [7:0] A_P2DIR = 8'h0c;
  localparam logic [7:0] A_P2DATA = 8'h10;
  localparam logic [7:0] A_P3OUT = 8'h14;
  localparam logic [7:0] A_BAUD = 8'h18;
  localparam logic [7:0] A_TXDATA = 8'h1c;
  localparam logic [7:0] A_RXDATA = 8'h20;
  localparam logic [7:0] A_MADDR = 8'h24;
  localparam logic [7:0] A_MDATA = 8'h28;
  localparam logic [7:0] A_MCMD = 8'h2c;
  localparam logic [7:0] A_STAT = 8'h30;
  // control register fields
  localparam int C_SER = 0;
  localparam int C_PAR = 1;
  localparam int C_P0HS = 2;
  localparam int C_P2HS = 3;
  localparam int C_EXT = 4;
  localparam int C_DM = 5;
  localparam int C_TOUT = 6;
  localparam int C_OD = 7;
  localparam logic [7:0] CTRL_RST = 8'h10;
  // port 0 config fields: nibble used as address, nibble is output
  localparam int Q_LOADR = 0;
  localparam int Q_HIADR = 1;
  localparam int Q_LOOUT = 2;
  localparam int Q_HIOUT = 3;
  localparam logic [3:0] P0CFG_RST = 4'h3;
  localparam int BIT_PORT_MSB = 7;
  // memory command fields
  localparam int M_GO = 0;
  localparam int M_WR = 1;
  localparam int M_DM = 2;
  // reset and bus timing in crystal periods, first fetch address, serial frame bit counts
  localparam logic [2:0] RST_FILT = 3'h4;
  localparam logic [2:0] RST_LATCH = 3'h5;
  localparam logic [4:0] RST_HOLD = 5'h12;
  localparam logic [2:0] DS_CLKS = 3'h3;
  localparam logic [2:0] EXT_CLKS = 3'h2;
  localparam logic [15:0] FETCH_ADDR = 16'h000c;
  localparam logic [3:0] FRAME_BITS = 4'hb;
  localparam logic [3:0] RX_STOP = 4'ha;
  typedef enum {M_IDLE, M_AS, M_ADR, M_DAT, M_DS, M_END} mem_st_t;
endpackage : pin_pkg

// ---- rtl/pin_logic.sv ----
// memory bus strobes, reset sequence, ports with handshake and serial unit
//
// Functional notes
// RL1: one data strobe per external transfer
// RL2: memory drives read data before strobe ends
// RL3: write data valid when data strobe falls
// RL4: address strobe once per cycle, address valid
// RL5: direction low on write, high on read
// RL6: reset pulses under four clocks ignored
// RL7: hold reset 18 clocks or pin length
// RL8: during reset strobe low, address strobe toggles
// RL9: first fetch after reset at 000c
// RL10: wait input low stalls the data strobe
// RL11: port 0 nibbles io or address, handshake
// RL12: after reset port 0 address, extended timing
// RL13: low nibble a11-a8, both nibbles a15-a8
// RL14: port 2 per-bit direction, global open drain
// RL15: port 2 handshake on in1/out6
// RL16: fixed port 3 inputs, outputs, alternates
// RL17: serial on rx/tx pins, timer 0 rate
// RL18: start, eight data, two stops, odd parity
// RL19: transmit interrupt per character
// RL20: remote sends start, eight data, stop
// RL21: receive parity flag, receive interrupt
// RL22: port 0 handshake on in2/out5
// RL23: handshake interlocked, data stable before strobe
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
module port_bus_uart_pin_logic #(
  parameter logic [15:0] BAUD_DIV = 16'h043c
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reset pin and memory strobes
  input wire logic ext_reset_n,
  input wire logic wait_n,
  output logic internal_reset_hold,
  output logic xfer_strobe_n,
  output logic cycle_addr_strobe_n,
  output logic rd_wr_dir,
  // bidirectional ports
  input wire logic [7:0] addr_port_i,
  output logic [7:0] addr_port_o,
  output logic [7:0] addr_port_oe,
  input wire logic [7:0] low_addr_port_i,
  output logic [7:0] low_addr_port_o,
  output logic [7:0] low_addr_port_oe,
  input wire logic [7:0] bit_port_i,
  output logic [7:0] bit_port_o,
  output logic [7:0] bit_port_oe,
  // port 3 fixed pins
  input wire logic serial_rx_pin,
  input wire logic ctl_in1,
  input wire logic ctl_in2,
  input wire logic ctl_in3,
  output logic ctl_out4,
  output logic ctl_out5,
  output logic ctl_out6,
  output logic serial_tx_pin,
  // serial events
  output logic rx_irq_line,
  output logic tx_irq_line
);
  import pin_pkg::*;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= A_STAT);
  endfunction : mapped

  function automatic logic odd_par(input logic [6:0] d);
    odd_par = ~^d;
  endfunction : odd_par

  logic [29:0] sy1_r, sy2_r;
  logic rst_s, wait_s, rx_s, c1_s, c2_s, c3_s;
  logic [7:0] p0_s, lo_s, p2_s;
  logic [7:0] ctrl_r, p0out_r, p2dir_r, p2out_r, mwdata_r, mrdata_r, rx_dat_r, lo_o_r;
  logic [3:0] p0cfg_r, p3out_r;
  logic [15:0] baud_r, maddr_r, cur_addr_r, t0_cnt_r, rx_cnt_r;
  logic [2:1] mcmd_r;
  logic [31:0] rdata;
  logic wr_en, rd_acc, mgo;
  logic [2:0] low_cnt_r, ds_cnt_r;
  logic [4:0] hold_cnt_r;
  logic hold_r, ds_n_r, as_n_r, rw_r, mbusy_r, fetch_r, mwr_r, dm_r, lo_oe_r;
  mem_st_t mst_r;
  logic [1:0] hs_en, hs_out, hs_in_s, hs_pin, hs_full_r, hs_on_r, hs_wr, hs_rd;
  logic [7:0] hs_dat_r [2];
  logic [7:0] hs_pins [2];
  logic t0_tick, tout_r, tx_busy, tx_irq_r, rx_irq_r, rx_full_r, perr_r, rx_prev_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_left_r, rx_bit_r;
  logic [7:0] rx_sh_r;

  // every pin input passes two flops; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1_r <= '1;
      sy2_r <= '1;
    end else if (ce) begin
      sy1_r <= {ext_reset_n, wait_n, serial_rx_pin, ctl_in1, ctl_in2, ctl_in3,
                addr_port_i, low_addr_port_i, bit_port_i};
      sy2_r <= sy1_r;
    end
  end
  assign {rst_s, wait_s, rx_s, c1_s, c2_s, c3_s, p0_s, lo_s, p2_s} = sy2_r;

  // reset filter: latch hold on the fifth consecutive low sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r <= 3'h0;
      hold_r <= 1'b0;
      hold_cnt_r <= 5'h0;
    end else if (ce) begin
      low_cnt_r <= rst_s ? 3'h0 : (low_cnt_r == RST_LATCH ? low_cnt_r : low_cnt_r + 3'h1); // [RL6]
      if (!hold_r && !rst_s && low_cnt_r == RST_FILT) begin
        hold_r <= 1'b1; // [RL7]
        hold_cnt_r <= 5'h0;
      end else if (hold_r) begin
        if (hold_cnt_r != RST_HOLD - 5'h1)
          hold_cnt_r <= hold_cnt_r + 5'h1;
        else if (rst_s)
          hold_r <= 1'b0; // [RL7]
      end
    end
  end
  assign internal_reset_hold = hold_r;

  // apb decode; a frozen clock enable stretches the access phase
  assign wr_en = psel && penable && pwrite && ce && mapped(paddr);
  assign rd_acc = psel && penable && !pwrite && ce;
  assign mgo = wr_en && paddr == A_MCMD && pwdata[M_GO] && !mbusy_r && !fetch_r;
  assign pready = ce;
  assign pslverr = psel && penable && !mapped(paddr);

  // software registers; the reset sequence restores port 0 and timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      p0cfg_r <= P0CFG_RST;
      {p0out_r, p2dir_r, p2out_r, mwdata_r} <= 32'h0;
      p3out_r <= 4'hf;
      baud_r <= BAUD_DIV;
      maddr_r <= 16'h0;
      mcmd_r <= 2'h0;
    end else if (ce) begin
      if (hold_r) begin
        ctrl_r <= CTRL_RST; // [RL12]
        p0cfg_r <= P0CFG_RST; // [RL12]
      end else if (wr_en) begin
        case (paddr)
          A_CTRL: ctrl_r <= pwdata[7:0];
          A_P0CFG: p0cfg_r <= pwdata[3:0]; // [RL11]
          A_P0DATA: p0out_r <= pwdata[7:0];
          A_P2DIR: p2dir_r <= pwdata[7:0]; // [RL14]
          A_P2DATA: p2out_r <= pwdata[7:0];
          A_P3OUT: p3out_r <= pwdata[3:0];
          A_BAUD: baud_r <= pwdata[15:0];
          A_MADDR: maddr_r <= pwdata[15:0];
          A_MDATA: mwdata_r <= pwdata[7:0];
          A_MCMD: mcmd_r <= pwdata[M_DM:M_WR];
          default: ;
        endcase
      end
    end
  end

  // read mux, registered in the setup phase so prdata comes from flops
  always_comb begin
    rdata = 32'h0;
    case (paddr)
      A_CTRL: rdata[7:0] = ctrl_r;
      A_P0CFG: rdata[3:0] = p0cfg_r;
      A_P0DATA: rdata[7:0] = (hs_en[0] && !hs_out[0]) ? hs_dat_r[0] : p0_s;
      A_P2DIR: rdata[7:0] = p2dir_r;
      A_P2DATA: rdata[7:0] = (hs_en[1] && !hs_out[1]) ? hs_dat_r[1] : p2_s;
      A_P3OUT: rdata[7:0] = {rx_s, c1_s, c2_s, c3_s, p3out_r};
      A_BAUD: rdata[15:0] = baud_r;
      A_RXDATA: rdata[7:0] = rx_dat_r;
      A_MADDR: rdata[15:0] = maddr_r;
      A_MDATA: rdata[7:0] = mrdata_r;
      A_MCMD: rdata[2:0] = {mcmd_r, mbusy_r};
      A_STAT: rdata[6:0] = {hs_full_r, hold_r, perr_r, rx_full_r, tx_busy, mbusy_r};
      default: rdata = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (ce && psel && !penable)
      prdata <= rdata;
  end

  // memory cycle: address strobe, data phase setup, data strobe, release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_r <= M_IDLE;
      {ds_n_r, as_n_r, rw_r, fetch_r} <= 4'hf;
      {mbusy_r, mwr_r, dm_r, lo_oe_r} <= 4'h0;
      ds_cnt_r <= 3'h0;
      cur_addr_r <= 16'h0;
      {mrdata_r, lo_o_r} <= 16'h0;
    end else if (ce) begin
      if (hold_r) begin
        mst_r <= M_IDLE;
        ds_n_r <= 1'b0; // [RL8]
        as_n_r <= ~as_n_r; // [RL8]
        {rw_r, fetch_r} <= 2'h3;
        {mbusy_r, dm_r, lo_oe_r} <= 3'h0;
      end else begin
        case (mst_r)
          M_IDLE: begin
            {ds_n_r, as_n_r} <= 2'h3;
            if (fetch_r || mgo) begin
              mst_r <= M_AS;
              as_n_r <= 1'b0; // [RL4]
              mbusy_r <= 1'b1;
              fetch_r <= 1'b0;
              cur_addr_r <= fetch_r ? FETCH_ADDR : maddr_r; // [RL9]
              mwr_r <= mgo && pwdata[M_WR];
              rw_r <= !(mgo && pwdata[M_WR]); // [RL5]
              dm_r <= mgo && pwdata[M_DM];
              lo_o_r <= fetch_r ? FETCH_ADDR[7:0] : maddr_r[7:0]; // [RL4]
              lo_oe_r <= 1'b1;
            end
          end
          M_AS: begin
            as_n_r <= 1'b1; // address valid at this rising edge [RL4]
            mst_r <= M_ADR;
          end
          M_ADR: begin
            // write data goes out a cycle before the strobe falls
            if (mwr_r)
              lo_o_r <= mwdata_r; // [RL3]
            else
              lo_oe_r <= 1'b0;
            mst_r <= M_DAT;
          end
          M_DAT: begin
            ds_n_r <= 1'b0; // [RL1]
            ds_cnt_r <= ctrl_r[C_EXT] ? DS_CLKS + EXT_CLKS - 3'h1 : DS_CLKS - 3'h1;
            mst_r <= M_DS;
          end
          M_DS: begin
            // wait is looked at only once the strobe is low
            if (ds_cnt_r != 3'h0)
              ds_cnt_r <= ds_cnt_r - 3'h1;
            else if (wait_s) begin // [RL10]
              ds_n_r <= 1'b1;
              mrdata_r <= lo_s; // [RL2]
              mst_r <= M_END;
            end
          end
          M_END: begin
            lo_oe_r <= 1'b0;
            {mbusy_r, dm_r} <= 2'h0;
            mst_r <= M_IDLE;
          end
          default: mst_r <= M_IDLE;
        endcase
      end
    end
  end
  assign xfer_strobe_n = ds_n_r;
  assign cycle_addr_strobe_n = as_n_r;
  assign rd_wr_dir = rw_r;
  assign low_addr_port_o = lo_o_r;
  assign low_addr_port_oe = {8{lo_oe_r}};

  // port 0: each nibble carries address or its own io data
  assign addr_port_o = {p0cfg_r[Q_HIADR] ? cur_addr_r[15:12] : p0out_r[7:4],
                        p0cfg_r[Q_LOADR] ? cur_addr_r[11:8] : p0out_r[3:0]}; // [RL13]
  assign addr_port_oe = {{4{p0cfg_r[Q_HIADR] | p0cfg_r[Q_HIOUT]}},
                         {4{p0cfg_r[Q_LOADR] | p0cfg_r[Q_LOOUT]}}}; // [RL11]
  // port 2: open drain only pulls low, ones float
  assign bit_port_o = p2out_r;
  assign bit_port_oe = p2dir_r & (ctrl_r[C_OD] ? ~p2out_r : 8'hff); // [RL14]

  // handshake: index 0 is port 0, index 1 is port 2
  assign hs_en = {ctrl_r[C_P2HS], ctrl_r[C_P0HS] && p0cfg_r[Q_HIADR:Q_LOADR] == 2'h0
                  && p0cfg_r[Q_HIOUT] == p0cfg_r[Q_LOOUT]}; // [RL11]
  assign hs_out = {p2dir_r[BIT_PORT_MSB], p0cfg_r[Q_HIOUT]}; // [RL15]
  assign hs_in_s = {c1_s, c2_s}; // [RL22]
  assign hs_wr = {wr_en && paddr == A_P2DATA, wr_en && paddr == A_P0DATA};
  assign hs_rd = {rd_acc && paddr == A_P2DATA, rd_acc && paddr == A_P0DATA};
  assign hs_pins[0] = p0_s;
  assign hs_pins[1] = p2_s;
  for (genvar k = 0; k < 2; k++) begin : g_hs
    // output side strobes only once data sits in the port register
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        {hs_full_r[k], hs_on_r[k]} <= 2'h0;
        hs_dat_r[k] <= 8'h0;
      end else if (ce) begin
        if (!hs_en[k])
          {hs_full_r[k], hs_on_r[k]} <= 2'h0;
        else if (hs_out[k]) begin
          if (hs_wr[k])
            hs_full_r[k] <= 1'b1;
          else if (hs_on_r[k] && !hs_in_s[k])
            {hs_full_r[k], hs_on_r[k]} <= 2'h0; // taken by receiver [RL23]
          if (hs_full_r[k] && !hs_on_r[k] && hs_in_s[k])
            hs_on_r[k] <= 1'b1; // [RL23]
        end else if (!hs_full_r[k] && !hs_in_s[k]) begin
          hs_full_r[k] <= 1'b1; // capture beats a read in the same cycle
          hs_dat_r[k] <= hs_pins[k];
        end else if (hs_rd[k])
          hs_full_r[k] <= 1'b0;
      end
    end
    assign hs_pin[k] = hs_out[k] ? ~hs_on_r[k] : (~hs_full_r[k] & hs_in_s[k]); // [RL23]
  end

  // counter/timer 0 sets the bit rate and drives the timer output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_cnt_r <= 16'h0;
      tout_r <= 1'b0;
    end else if (ce) begin
      t0_cnt_r <= t0_tick ? baud_r : t0_cnt_r - 16'h1; // [RL17]
      if (t0_tick)
        tout_r <= ~tout_r;
    end
  end
  assign t0_tick = t0_cnt_r == 16'h0;

  // transmitter: start, eight bits, two stops, lsb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_r <= '1;
      tx_left_r <= 4'h0;
      tx_irq_r <= 1'b0;
    end else if (ce) begin
      tx_irq_r <= 1'b0;
      if (!tx_busy && wr_en && paddr == A_TXDATA && ctrl_r[C_SER]) begin
        tx_sh_r <= {2'h3, ctrl_r[C_PAR] ? odd_par(pwdata[6:0]) : pwdata[7],
                    pwdata[6:0], 1'b0}; // [RL18]
        tx_left_r <= FRAME_BITS;
      end else if (tx_busy && t0_tick) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_left_r <= tx_left_r - 4'h1;
        tx_irq_r <= tx_left_r == 4'h1; // [RL19]
      end
    end
  end
  assign tx_busy = tx_left_r != 4'h0;

  // receiver: sample mid-bit, false start drops back to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {rx_prev_r, rx_full_r, perr_r, rx_irq_r} <= 4'h8;
      rx_cnt_r <= 16'h0;
      rx_bit_r <= 4'h0;
      {rx_sh_r, rx_dat_r} <= 16'h0;
    end else if (ce) begin
      rx_prev_r <= rx_s;
      rx_irq_r <= 1'b0;
      if (rd_acc && paddr == A_RXDATA)
        rx_full_r <= 1'b0;
      if (rx_bit_r == 4'h0) begin
        if (ctrl_r[C_SER] && rx_prev_r && !rx_s) begin // [RL17]
          rx_bit_r <= 4'h1;
          rx_cnt_r <= {1'b0, baud_r[15:1]};
        end
      end else if (rx_cnt_r != 16'h0)
        rx_cnt_r <= rx_cnt_r - 16'h1;
      else begin
        rx_cnt_r <= baud_r;
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h1 && rx_s)
          rx_bit_r <= 4'h0;
        else if (rx_bit_r != RX_STOP)
          rx_sh_r <= {rx_s, rx_sh_r[7:1]};
        else begin
          rx_bit_r <= 4'h0;
          rx_dat_r <= ctrl_r[C_PAR] ? {^rx_sh_r == 1'b0, rx_sh_r[6:0]} : rx_sh_r; // [RL21]
          perr_r <= ctrl_r[C_PAR] && ^rx_sh_r == 1'b0;
          rx_full_r <= 1'b1; // set wins over a read
          rx_irq_r <= 1'b1; // [RL21]
        end
      end
    end
  end

  // port 3 outputs with their alternate functions
  assign ctl_out4 = ctrl_r[C_DM] ? ~dm_r : p3out_r[0]; // [RL16]
  assign ctl_out5 = hs_en[0] ? hs_pin[0] : p3out_r[1]; // [RL22]
  assign ctl_out6 = hs_en[1] ? hs_pin[1] : (ctrl_r[C_TOUT] ? tout_r : p3out_r[2]); // [RL15]
  assign serial_tx_pin = ctrl_r[C_SER] ? tx_sh_r[0] | ~tx_busy : p3out_r[3]; // [RL17]
  assign tx_irq_line = tx_irq_r;
  assign rx_irq_line = rx_irq_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  chk_ds_once: assert property ($fell(ds_n_r) && !hold_r |-> $past(mst_r) == M_DAT) // [RL1]
    else $error("data strobe fell outside a transfer");
  chk_wr_data: assert property ($fell(ds_n_r) && !rw_r |-> lo_oe_r && $stable(lo_o_r)) // [RL3]
    else $error("write data not stable at strobe");
  chk_addr_strobe: assert property ($rose(as_n_r) && !hold_r && !$past(hold_r) // [RL4]
    |-> lo_o_r == cur_addr_r[7:0] && $past(mst_r) == M_AS ##2 $fell(ds_n_r))
    else $error("address strobe sequence wrong");
  chk_dir_level: assert property (mst_r == M_DS |-> rw_r == !mwr_r && !ds_n_r) // [RL5]
    else $error("direction wrong during transfer");
  chk_reset_filter: assert property ($rose(hold_r) |-> $past(low_cnt_r) == RST_FILT) // [RL6]
    else $error("reset latched without filter count");
  chk_reset_hold: assert property ($fell(hold_r) |-> $past(hold_cnt_r) == RST_HOLD - 5'h1 // [RL7]
    && $past(rst_s))
    else $error("reset hold released early");
  chk_reset_strobes: assert property (hold_r && $past(hold_r) |-> !ds_n_r // [RL8]
    && as_n_r != $past(as_n_r))
    else $error("strobes wrong during reset");
  chk_fetch_start: assert property ($fell(hold_r) |=> mst_r == M_AS // [RL9]
    && cur_addr_r == FETCH_ADDR)
    else $error("first fetch not at reset address");
  chk_wait_stall: assert property (mst_r == M_DS && ds_cnt_r == 3'h0 && !wait_s // [RL10]
    |=> mst_r == M_DS && !ds_n_r)
    else $error("wait did not stall the strobe");
  chk_tx_frame: assert property ($rose(tx_busy) |-> !tx_sh_r[0] && tx_sh_r[10:9] == 2'h3 // [RL18]
    && tx_left_r == FRAME_BITS)
    else $error("transmit frame malformed");
  chk_tx_irq: assert property (tx_irq_r |-> !tx_busy && $past(tx_busy)) // [RL19]
    else $error("transmit interrupt misplaced");
  chk_rx_irq: assert property (rx_irq_r |-> rx_full_r && rx_bit_r == 4'h0) // [RL21]
    else $error("receive interrupt without character");

  cov_fetch: cover property ($fell(mbusy_r) && rw_r);
  cov_wait_write: cover property (mst_r == M_DS && !mwr_r == 1'b0 && !wait_s);
  cov_tx_char: cover property (tx_irq_r);
  cov_rx_char: cover property (rx_irq_r && ctrl_r[C_PAR]);
endmodule : port_bus_uart_pin_logic

// ---- testbench/ext_mem_model.sv ----
// external memory model answering the device bus, with optional wait states
`timescale 1ns/10ps
module ext_mem_model (
  // bus from the device
  input wire logic pclk,
  input wire logic xfer_strobe_n,
  input wire logic cycle_addr_strobe_n,
  input wire logic rd_wr_dir,
  input wire logic [7:0] addr_port_o,
  input wire logic [7:0] low_addr_port_o,
  input wire logic slow,
  // answers and observations
  output logic [7:0] low_addr_port_i,
  output logic wait_n,
  output logic [15:0] addr_r,
  output logic [7:0] wdata_r,
  output logic dir_r
);
  logic [7:0] last_r = 8'h00;
  logic ds_q = 1'b1;
  int wcnt = 0;
  // read data only while the strobe is low; a released bus flips every cycle
  assign low_addr_port_i = (!xfer_strobe_n && rd_wr_dir) ?
    (addr_r[7:0] ^ addr_r[15:8] ^ 8'h5a) : ~last_r;
  // wait pin is driven high while the stall count is zero, so it reads high when nobody stalls
  assign wait_n = (wcnt == 0);
  // address taken while the address strobe is low, valid at its rise
  always @(posedge pclk) begin
    last_r <= low_addr_port_i;
    ds_q <= xfer_strobe_n;
    if (!cycle_addr_strobe_n) begin
      addr_r <= {addr_port_o, low_addr_port_o};
    end
    if (ds_q && !xfer_strobe_n) begin
      wdata_r <= low_addr_port_o;
      dir_r <= rd_wr_dir;
    end
    // slow memory stalls from the start of the cycle, long before the count ends
    if (!cycle_addr_strobe_n && slow) begin
      wcnt <= 10;
    end else if (wcnt > 0) begin
      wcnt <= wcnt - 1;
    end
  end
endmodule : ext_mem_model

// ---- testbench/port_bus_uart_pin_logic_tb.sv ----
// self-checking bench for the pin, memory bus and serial logic
`timescale 1ns/10ps
module port_bus_uart_pin_logic_tb;
  import pin_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, addr_port_i = 8'ha5, bit_port_i = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, r;
  logic pready, pslverr, ext_reset_n = 1'b1, wait_n, internal_reset_hold, xfer_strobe_n;
  logic cycle_addr_strobe_n, rd_wr_dir, serial_rx_pin = 1'b1, slow = 1'b0, err, od;
  logic ctl_in1 = 1'b0, ctl_in2 = 1'b1, ctl_in3 = 1'b0, ctl_out4, ctl_out5, ctl_out6;
  logic [7:0] addr_port_o, addr_port_oe, low_addr_port_i, low_addr_port_o, low_addr_port_oe;
  logic [7:0] bit_port_o, bit_port_oe, m_wdata, d;
  logic serial_tx_pin, rx_irq_line, tx_irq_line, m_dir, ds_q = 1'b1, as_q = 1'b1;
  logic h_q = 1'b0, h_qq = 1'b0;
  logic [15:0] m_addr, a;
  logic [127:0] txh = '1, txs;
  int mismatches = 0, cmp_count = 0, ds_falls = 0, ds_len = 0, hold_len = 0, holds = 0;
  int rx_n = 0, tx_n = 0, bad8 = 0, f, n;

  always #4 pclk = ~pclk;

  port_bus_uart_pin_logic #(.BAUD_DIV(16'h0007)) dut_u (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_reset_n, .wait_n,
    .internal_reset_hold, .xfer_strobe_n, .cycle_addr_strobe_n, .rd_wr_dir, .addr_port_i,
    .addr_port_o, .addr_port_oe, .low_addr_port_i, .low_addr_port_o, .low_addr_port_oe,
    .bit_port_i, .bit_port_o, .bit_port_oe, .serial_rx_pin, .ctl_in1, .ctl_in2, .ctl_in3,
    .ctl_out4, .ctl_out5, .ctl_out6, .serial_tx_pin, .rx_irq_line, .tx_irq_line);

  ext_mem_model mem_u (.pclk, .xfer_strobe_n, .cycle_addr_strobe_n, .rd_wr_dir, .addr_port_o,
    .low_addr_port_o, .slow, .low_addr_port_i, .wait_n, .addr_r(m_addr), .wdata_r(m_wdata),
    .dir_r(m_dir));

  // strobe, hold and event bookkeeping; the first two hold cycles are skipped for latency
  always @(posedge pclk) begin
    ds_q <= xfer_strobe_n;
    as_q <= cycle_addr_strobe_n;
    h_q <= internal_reset_hold;
    h_qq <= h_q;
    txh <= {txh[126:0], serial_tx_pin};
    if (ds_q && !xfer_strobe_n) ds_falls <= ds_falls + 1;
    if (!xfer_strobe_n) ds_len <= ds_q ? 1 : ds_len + 1;
    if (internal_reset_hold) hold_len <= h_q ? hold_len + 1 : 1;
    if (internal_reset_hold && !h_q) holds <= holds + 1;
    if (internal_reset_hold && h_q && h_qq &&
        (xfer_strobe_n !== 1'b0 || cycle_addr_strobe_n === as_q)) bad8 <= bad8 + 1;
    if (rx_irq_line) rx_n <= rx_n + 1;
    if (tx_irq_line) tx_n <= tx_n + 1;
    if (tx_irq_line) txs <= {txh[126:0], serial_tx_pin};
  end

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // a used-up wait counts as a mismatch and ends the run
  task automatic tmo(input int cnt, input int lim);
    if (cnt >= lim) begin
      chk(cnt, 0);
      test_done();
    end
  endtask : tmo

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    tmo(k, 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 60);
    tmo(k, 60);
  endtask : wait_idle

  function automatic logic [10:0] frame(input logic [7:0] b, input logic p);
    logic [7:0] x;
    x = b;
    if (p) x[7] = ~^b[6:0];  // odd parity over the low seven bits
    return {2'b11, x, 1'b0};
  endfunction : frame

  // bits are read back from the snapshot taken when the last stop bit ends
  task automatic tx_char(input logic [7:0] b, input logic p);
    logic [10:0] g;
    int t0, k;
    t0 = tx_n;
    k = 0;
    apb(1'b1, A_TXDATA, {24'h0, b});
    while (tx_n == t0 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    tmo(k, 200);
    for (int i = 0; i < 11; i++) g[i] = txs[8 * (10 - i) + 1];
    chk(g, frame(b, p));
  endtask : tx_char

  // remote sender: start, eight data bits, one stop, eight clocks a bit
  task automatic rx_char(input logic [7:0] b, input logic p);
    logic [9:0] fr;
    int t0, k;
    fr = {1'b1, b, 1'b0};
    t0 = rx_n;
    k = 0;
    for (int i = 0; i < 10; i++) begin
      serial_rx_pin <= fr[i];
      repeat (8) @(posedge pclk);
    end
    while (rx_n == t0 && k < 40) begin
      @(posedge pclk);
      k++;
    end
    tmo(k, 40);
    apb(1'b0, A_RXDATA, 32'h0);
    chk(rd[7:0], p ? {~^b, b[6:0]} : b);
  endtask : rx_char

  task automatic ext_pulse(input int len);
    ext_reset_n <= 1'b0;
    repeat (len) @(posedge pclk);
    ext_reset_n <= 1'b1;
    repeat (12) @(posedge pclk);
    n = 0;
    while (internal_reset_hold !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    tmo(n, 100);
  endtask : ext_pulse

  // main sequence
  initial begin
    r = $urandom(32'h364f);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_idle();
    chk(m_addr, FETCH_ADDR);
    chk(m_dir, 1'b1);
    chk(ds_len, 5);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, A_P0CFG, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, 8'h34, 32'h0);
    chk(err, 1'b1);
    // random writes and reads; later passes use low nibble only, then slow memory
    for (int i = 0; i < 6; i++) begin
      a = $urandom;
      d = $urandom;
      slow = (i == 5);
      if (i == 3) apb(1'b1, A_P0CFG, 32'h1);
      if (i == 4) apb(1'b1, A_CTRL, 32'h0);
      apb(1'b1, A_MADDR, {16'h0, a});
      apb(1'b1, A_MDATA, {24'h0, d});
      f = ds_falls;
      apb(1'b1, A_MCMD, 32'h3);
      wait_idle();
      chk(ds_falls, f + 1);
      chk(m_addr[11:0], a[11:0]);
      chk(m_wdata, d);
      chk(m_dir, 1'b0);
      if (i < 3) chk(m_addr[15:12], a[15:12]);
      else chk(addr_port_oe[7:4], 4'h0);
      apb(1'b1, A_MCMD, 32'h1);
      wait_idle();
      chk(m_dir, 1'b1);
      if (i == 4) chk(ds_len, 3);
      if (i == 5) chk(ds_len > 5, 1'b1);
      apb(1'b0, A_MDATA, 32'h0);
      chk(rd[7:0], a[7:0] ^ (i < 3 ? a[15:8] : a[11:8]) ^ 8'h5a);
    end
    slow = 1'b0;
    // port 2 direction and open drain
    for (int i = 0; i < 4; i++) begin
      a = $urandom;
      od = i[0];
      {ctl_in1, ctl_in2, ctl_in3} <= a[2:0];
      bit_port_i <= a[15:8];
      apb(1'b1, A_CTRL, {24'h0, od, 7'h0});
      apb(1'b1, A_P2DIR, {24'h0, a[7:0]});
      apb(1'b1, A_P2DATA, {24'h0, a[15:8]});
      @(negedge pclk);
      chk(bit_port_oe, a[7:0] & (od ? ~a[15:8] : 8'hff));
    end
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_P3OUT, 32'ha);
    @(negedge pclk);
    chk({serial_tx_pin, ctl_out6, ctl_out5, ctl_out4}, 4'ha);
    // handshake both ways
    {ctl_in1, ctl_in2} <= 2'h3;
    apb(1'b1, A_CTRL, 32'hc);
    apb(1'b1, A_P0CFG, 32'h0);
    apb(1'b1, A_P2DIR, 32'h80);
    apb(1'b1, A_P2DATA, 32'h5a);
    repeat (4) @(posedge pclk);
    chk({ctl_out6, ctl_out5}, 2'h1);
    {ctl_in1, ctl_in2, addr_port_i} <= 10'h0c3;
    repeat (4) @(posedge pclk);
    chk({ctl_out6, ctl_out5}, 2'h2);
    addr_port_i <= 8'h3c;
    apb(1'b0, A_P0DATA, 32'h0);
    chk(rd[7:0], 8'hc3);
    // serial both ways, without and with parity
    apb(1'b1, A_BAUD, 32'h7);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_CTRL, {30'h0, i[1], 1'b1});
      tx_char($urandom, i[1]);
      rx_char($urandom, i[1]);
    end
    // reset filter, hold length and restart
    apb(1'b1, A_CTRL, 32'h0);
    ext_pulse(3);
    chk(holds, 0);
    ext_pulse(6);
    chk(holds, 1);
    chk(hold_len, 18);
    wait_idle();
    chk(m_addr, FETCH_ADDR);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h10);
    ext_pulse(40);
    chk(hold_len > 30 && hold_len < 42, 1'b1);
    chk(bad8, 0);
    test_done();
  end
endmodule : port_bus_uart_pin_logic_tb
